// *** addr_xlat_defs.vh ***
`ifndef ADDR_XLAT_DEFS_VH
`define ADDR_XLAT_DEFS_VH

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_MGMT_BASE 8'h04
`define OFS_INDEX     8'h08
`define OFS_SEG_BASE  8'h0C
`define OFS_SEG_LIMIT 8'h10
`define OFS_PG_TAG    8'h14
`define OFS_PG_CFG    8'h18
`define OFS_PG_FRAME  8'h1C
`define OFS_STATUS    8'h20
`define OFS_LAST_LO   8'h24
`define OFS_LAST_HI   8'h28

// control fields
`define CTRL_MODE_LSB  0
`define CTRL_MODEL_LSB 4
`define CTRL_PAGING    8
`define CTRL_PHYS_EXT  9
`define CTRL_LARGE     10
`define CTRL_LM_SUP    11
`define CTRL_CS_D      12
`define CTRL_RESET     32'h0000_0001
`define MGMT_RESET     32'h0003_0000

// index fields
`define IDX_SEG_LSB 0
`define IDX_PG_LSB  8

// page entry config fields
`define PGCFG_VALID     0
`define PGCFG_LARGE     1
`define PGCFG_TAGHI_LSB 8
`define PGCFG_FRMHI_LSB 16

// status fields
`define STAT_FAULT_LSB 0
`define STAT_MODE_LSB  4
`define STAT_MODEL_LSB 8
`define STAT_ASIZE_LSB 10

// operating modes
`define MODE_PROT   3'h0
`define MODE_REAL   3'h1
`define MODE_MGMT   3'h2
`define MODE_COMPAT 3'h3
`define MODE_LONG   3'h4

// memory models
`define MODEL_FLAT 2'h0
`define MODEL_SEG  2'h1
`define MODEL_REAL 2'h2

// address sizes
`define ASZ_16 2'h0
`define ASZ_32 2'h1
`define ASZ_64 2'h2

// fault codes
`define FLT_NONE   3'h0
`define FLT_LIMIT  3'h1
`define FLT_NULL   3'h2
`define FLT_CANON  3'h3
`define FLT_PGMISS 3'h4
`define FLT_RANGE  3'h5
`define FLT_CONFIG 3'h6

// address limits
`define REAL_SPACE_W 20
`define SEG_MAX_COUNT 16383

`endif

// *** addr_xlat.v ***
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`include "addr_xlat_defs.vh"

module addr_xlat #(
  parameter SEG_IW    = 3,
  parameter PG_IW     = 2,
  parameter PHYS_W    = 36,
  parameter LM_PHYS_W = 46,
  parameter LIN_W     = 48
) (
  // clock and reset
  input  wire                 clk_i,
  input  wire                 rst_i,
  // wishbone slave
  input  wire                 cyc_i,
  input  wire                 stb_i,
  input  wire                 we_i,
  input  wire [7:0]           adr_i,
  input  wire [3:0]           sel_i,
  input  wire [31:0]          dat_i,
  output reg  [31:0]          dat_o,
  output reg                  ack_o,
  // request from execution pipeline
  input  wire                 req_valid_i,
  input  wire [15:0]          selector_i,
  input  wire [63:0]          offset_i,
  input  wire                 fsgs_i,
  input  wire                 addr_ovr_i,
  input  wire                 boundary_i,
  // answer towards memory bus
  output reg                  pa_valid_o,
  output reg  [LM_PHYS_W-1:0] pa_o,
  output reg  [63:0]          lin_o,
  output reg                  fault_o,
  output reg  [2:0]           fault_code_o,
  output reg                  mgmt_space_o
);

  localparam SEG_N = 1 << SEG_IW;
  localparam PG_N  = 1 << PG_IW;
  localparam TAG_W = LIN_W - 12;
  localparam FRM_W = LM_PHYS_W - 12;

  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer      k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        bmerge[k*8 +: 8] = s[k] ? d[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // software registers and active copies
  reg  [31:0]          ctrl_q;
  reg  [31:0]          act_q;
  reg  [31:0]          mgmt_base_q;
  reg  [31:0]          act_mgmt_q;
  reg  [15:0]          index_q;
  reg  [2:0]           last_fault_q;
  reg  [1:0]           last_asz_q;
  reg                  ack_q;
  wire                 wr_en;
  wire [SEG_IW-1:0]    seg_widx;
  wire [PG_IW-1:0]     pg_widx;
  wire [31:0]          idx_new;
  wire [SEG_N*32-1:0]  seg_base_all;
  wire [SEG_N*32-1:0]  seg_lim_all;
  wire [PG_N*32-1:0]   pg_cfg_all;
  wire [PG_N*32-1:0]   pg_tag_all;
  wire [PG_N*32-1:0]   pg_frm_all;
  wire [PG_N-1:0]      pg_hit;
  wire [PG_N*FRM_W-1:0] pg_pfn_all;

  assign wr_en    = cyc_i & stb_i & we_i & ack_q;
  assign seg_widx = index_q[`IDX_SEG_LSB +: SEG_IW];
  assign pg_widx  = index_q[`IDX_PG_LSB +: PG_IW];
  assign idx_new  = bmerge({16'h0000, index_q}, dat_i, sel_i);

  // decoded active settings
  wire [2:0] mode      = act_q[`CTRL_MODE_LSB +: 3];
  wire       is64      = (mode == `MODE_LONG);
  wire       real_like = (mode == `MODE_REAL) | (mode == `MODE_MGMT);
  wire       prot_like = (mode == `MODE_PROT) | (mode == `MODE_COMPAT) | is64;
  wire       pg_on     = act_q[`CTRL_PAGING] & prot_like;
  wire       physical_address_extension = act_q[`CTRL_PHYS_EXT] & prot_like;
  wire       large_on  = act_q[`CTRL_LARGE];

  // wishbone handshake and register writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_q       <= 1'b0;
      ctrl_q      <= `CTRL_RESET;
      mgmt_base_q <= `MGMT_RESET;
      index_q     <= 16'h0000;
    end else begin
      ack_q <= cyc_i & stb_i & ~ack_q;
      if (wr_en && adr_i == `OFS_CTRL) begin
        ctrl_q <= bmerge(ctrl_q, dat_i, sel_i);
      end
      if (wr_en && adr_i == `OFS_MGMT_BASE) begin
        mgmt_base_q <= bmerge(mgmt_base_q, dat_i, sel_i);
      end
      if (wr_en && adr_i == `OFS_INDEX) begin
        index_q <= idx_new[15:0];
      end
    end
  end

  // settings take effect only at an instruction boundary
  always @(posedge clk_i) begin
    if (rst_i) begin
      act_q      <= `CTRL_RESET;
      act_mgmt_q <= `MGMT_RESET;
    end else if (boundary_i) begin
      act_q      <= ctrl_q;
      act_mgmt_q <= mgmt_base_q;
    end
  end

  // effective address truncated to the current size
  reg  [1:0]  asz;
  reg  [63:0] eff;
  reg  [1:0]  model;
  always @* begin
    if (is64) begin
      asz = addr_ovr_i ? `ASZ_32 : `ASZ_64;
    end else if (real_like) begin
      asz = addr_ovr_i ? `ASZ_32 : `ASZ_16;
    end else begin
      asz = (act_q[`CTRL_CS_D] ^ addr_ovr_i) ? `ASZ_32 : `ASZ_16;
    end
    case (asz)
      `ASZ_16: eff = {48'h0000_0000_0000, offset_i[15:0]};
      `ASZ_32: eff = {32'h0000_0000, offset_i[31:0]};
      default: eff = offset_i;
    endcase
    if (is64) begin
      model = `MODEL_FLAT;
    end else if (real_like) begin
      model = `MODEL_REAL;
    end else if (act_q[`CTRL_MODEL_LSB +: 2] == `MODEL_SEG) begin
      model = `MODEL_SEG;
    end else if (act_q[`CTRL_MODEL_LSB +: 2] == `MODEL_REAL) begin
      model = `MODEL_REAL;
    end else begin
      model = `MODEL_FLAT;
    end
  end

  // segment table, one entry per generate step
  genvar g;
  generate
    for (g = 0; g < SEG_N; g = g + 1) begin : seg_ent
      reg [31:0] base_q;
      reg [31:0] lim_q;
      always @(posedge clk_i) begin
        if (rst_i) begin
          base_q <= 32'h0000_0000;
          lim_q  <= 32'hFFFF_FFFF;
        end else begin
          if (wr_en && adr_i == `OFS_SEG_BASE && seg_widx == g) begin
            base_q <= bmerge(base_q, dat_i, sel_i);
          end
          if (wr_en && adr_i == `OFS_SEG_LIMIT && seg_widx == g) begin
            lim_q <= bmerge(lim_q, dat_i, sel_i);
          end
        end
      end
      assign seg_base_all[g*32 +: 32] = base_q;
      assign seg_lim_all[g*32 +: 32]  = lim_q;
    end
  endgenerate

  // page map entries with parallel compare
  reg [63:0] lin;
  generate
    for (g = 0; g < PG_N; g = g + 1) begin : pg_ent
      reg             vld_q;
      reg             lrg_q;
      reg [TAG_W-1:0] tag_q;
      reg [FRM_W-1:0] frm_q;
      wire [31:0]     cfg;
      wire [31:0]     cfg_new;
      wire            big;
      assign cfg = (vld_q << `PGCFG_VALID) | (lrg_q << `PGCFG_LARGE)
                 | ({{(32-TAG_W+32){1'b0}}, tag_q[TAG_W-1:32]} << `PGCFG_TAGHI_LSB)
                 | ({{(32-FRM_W+32){1'b0}}, frm_q[FRM_W-1:32]} << `PGCFG_FRMHI_LSB);
      assign cfg_new = bmerge(cfg, dat_i, sel_i);
      always @(posedge clk_i) begin
        if (rst_i) begin
          vld_q <= 1'b0;
          lrg_q <= 1'b0;
          tag_q <= {TAG_W{1'b0}};
          frm_q <= {FRM_W{1'b0}};
        end else begin
          if (wr_en && adr_i == `OFS_PG_TAG && pg_widx == g) begin
            tag_q[31:0] <= bmerge(tag_q[31:0], dat_i, sel_i);
          end
          if (wr_en && adr_i == `OFS_PG_FRAME && pg_widx == g) begin
            frm_q[31:0] <= bmerge(frm_q[31:0], dat_i, sel_i);
          end
          if (wr_en && adr_i == `OFS_PG_CFG && pg_widx == g) begin
            vld_q             <= cfg_new[`PGCFG_VALID];
            lrg_q             <= cfg_new[`PGCFG_LARGE];
            tag_q[TAG_W-1:32] <= cfg_new[`PGCFG_TAGHI_LSB +: TAG_W-32];
            frm_q[FRM_W-1:32] <= cfg_new[`PGCFG_FRMHI_LSB +: FRM_W-32];
          end
        end
      end
      // large entries cover 4 MBytes when the large page option is on
      assign big = lrg_q & large_on;
      assign pg_hit[g] = vld_q & (big ? (tag_q[TAG_W-1:10] == lin[LIN_W-1:22])
                                      : (tag_q == lin[LIN_W-1:12]));
      assign pg_pfn_all[g*FRM_W +: FRM_W] = big ? {frm_q[FRM_W-1:10], lin[21:12]} : frm_q;
      assign pg_cfg_all[g*32 +: 32] = cfg;
      assign pg_tag_all[g*32 +: 32] = tag_q[31:0];
      assign pg_frm_all[g*32 +: 32] = frm_q[31:0];
    end
  endgenerate

  // logical to linear to physical
  wire [SEG_IW-1:0] seg_ridx  = selector_i[SEG_IW+2:3];
  wire [31:0]       sel_base  = seg_base_all[seg_ridx*32 +: 32];
  wire [31:0]       sel_lim   = seg_lim_all[seg_ridx*32 +: 32];
  reg  [63:0]       base;
  reg  [63:0]       lin_sum;
  reg  [2:0]        fault;
  reg  [FRM_W-1:0]  pfn;
  reg               hit;
  reg  [63:0]       pa_full;
  integer           i;
  always @* begin
    if (is64) begin
      base = fsgs_i ? {32'h0000_0000, sel_base} : 64'h0000_0000_0000_0000;
    end else if (model == `MODEL_REAL) begin
      base = {44'h0000_0000_000, selector_i, 4'h0};
    end else if (model == `MODEL_SEG) begin
      base = {32'h0000_0000, sel_base};
    end else begin
      base = 64'h0000_0000_0000_0000;
    end
    lin_sum = base + eff;
    if (is64) begin
      lin = lin_sum;
    end else if (real_like) begin
      lin = {{(64-`REAL_SPACE_W){1'b0}}, lin_sum[`REAL_SPACE_W-1:0]};
    end else begin
      lin = {32'h0000_0000, lin_sum[31:0]};
    end
  end

  // page lookup kept apart from the linear sum so no loop runs through one process
  always @* begin
    fault = `FLT_NONE;
    hit   = 1'b0;
    pfn   = {FRM_W{1'b0}};
    for (i = PG_N - 1; i >= 0; i = i - 1) begin
      if (pg_hit[i]) begin
        hit = 1'b1;
        pfn = pg_pfn_all[i*FRM_W +: FRM_W];
      end
    end
    if (!pg_on) begin
      pa_full = lin;
    end else if (physical_address_extension) begin
      pa_full = {{(64-LM_PHYS_W){1'b0}}, pfn, lin[11:0]};
    end else begin
      pa_full = {32'h0000_0000, pfn[19:0], lin[11:0]};
    end
    if (mode == `MODE_MGMT) begin
      pa_full = {32'h0000_0000, act_mgmt_q} + lin;
    end
    if (!is64) begin
      pa_full = pa_full & ((64'h0000_0000_0000_0001 << PHYS_W) - 64'h0000_0000_0000_0001);
    end
    if ((is64 || mode == `MODE_COMPAT) && !act_q[`CTRL_LM_SUP]) begin
      fault = `FLT_CONFIG;
    end else if (mode > `MODE_LONG) begin
      fault = `FLT_CONFIG;
    end else if (is64 && !(pg_on && physical_address_extension)) begin
      fault = `FLT_CONFIG;
    end else if (model == `MODEL_SEG && selector_i[15:2] == 14'h0000) begin
      fault = `FLT_NULL;
    end else if (model == `MODEL_SEG && eff[31:0] > sel_lim) begin
      fault = `FLT_LIMIT;
    end else if (real_like && asz == `ASZ_32 && lin_sum[63:`REAL_SPACE_W] != 44'h000_0000_0000) begin
      fault = `FLT_RANGE;
    end else if (is64 && lin[63:LIN_W-1] != {(65-LIN_W){lin[LIN_W-1]}}) begin
      fault = `FLT_CANON;
    end else if (pg_on && mode != `MODE_MGMT && !hit) begin
      fault = `FLT_PGMISS;
    end
  end

  // registered answer, one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      pa_valid_o   <= 1'b0;
      pa_o         <= {LM_PHYS_W{1'b0}};
      lin_o        <= 64'h0000_0000_0000_0000;
      fault_o      <= 1'b0;
      fault_code_o <= `FLT_NONE;
      mgmt_space_o <= 1'b0;
      last_fault_q <= `FLT_NONE;
      last_asz_q   <= `ASZ_16;
    end else begin
      pa_valid_o <= req_valid_i & (fault == `FLT_NONE);
      fault_o    <= req_valid_i & (fault != `FLT_NONE);
      if (req_valid_i) begin
        pa_o         <= pa_full[LM_PHYS_W-1:0];
        lin_o        <= lin;
        fault_code_o <= fault;
        mgmt_space_o <= (mode == `MODE_MGMT);
        last_fault_q <= fault;
        last_asz_q   <= asz;
      end
    end
  end

  // register read mux
  reg [31:0] rd;
  always @* begin
    case (adr_i)
      `OFS_CTRL:      rd = ctrl_q;
      `OFS_MGMT_BASE: rd = mgmt_base_q;
      `OFS_INDEX:     rd = {16'h0000, index_q};
      `OFS_SEG_BASE:  rd = seg_base_all[seg_widx*32 +: 32];
      `OFS_SEG_LIMIT: rd = seg_lim_all[seg_widx*32 +: 32];
      `OFS_PG_TAG:    rd = pg_tag_all[pg_widx*32 +: 32];
      `OFS_PG_CFG:    rd = pg_cfg_all[pg_widx*32 +: 32];
      `OFS_PG_FRAME:  rd = pg_frm_all[pg_widx*32 +: 32];
      `OFS_STATUS:    rd = ({29'h0000_0000, last_fault_q} << `STAT_FAULT_LSB)
                         | ({29'h0000_0000, mode} << `STAT_MODE_LSB)
                         | ({30'h0000_0000, model} << `STAT_MODEL_LSB)
                         | ({30'h0000_0000, last_asz_q} << `STAT_ASIZE_LSB);
      `OFS_LAST_LO:   rd = pa_o[31:0];
      `OFS_LAST_HI:   rd = {{(64-LM_PHYS_W){1'b0}}, pa_o[LM_PHYS_W-1:32]};
      default:        rd = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_q;
      dat_o <= rd;
    end
  end

endmodule // addr_xlat

// *** addr_xlat_assertions.sv ***
`timescale 1ns/100ps
module addr_xlat_assertions #(
  parameter LM_PHYS_W = 46
) (
  // clock and reset
  input wire                 clk_i,
  input wire                 rst_i,
  // register bus
  input wire                 cyc_i,
  input wire                 stb_i,
  input wire                 we_i,
  input wire [7:0]           adr_i,
  input wire [3:0]           sel_i,
  input wire [31:0]          dat_i,
  input wire                 ack_o,
  // translate request
  input wire                 req_valid_i,
  input wire [63:0]          offset_i,
  input wire                 fsgs_i,
  input wire                 addr_ovr_i,
  input wire                 boundary_i,
  // translate answer
  input wire                 pa_valid_o,
  input wire [LM_PHYS_W-1:0] pa_o,
  input wire [63:0]          lin_o,
  input wire                 fault_o,
  input wire                 mgmt_space_o
);
  reg [31:0] ctrl_q;
  reg [31:0] act_q;
  reg [31:0] use_q;
  reg [63:0] off_q;
  reg        fs_q;
  reg        ovr_q;
  integer    i;
  wire [2:0] md = use_q[2:0];

  // shadow of control, active settings and the settings each request used
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 32'h0000_0001;
      act_q  <= 32'h0000_0001;
    end else begin
      for (i = 0; i < 4; i = i + 1)
        if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00 && sel_i[i])
          ctrl_q[8*i+:8] <= dat_i[8*i+:8];
      if (boundary_i)
        act_q <= ctrl_q;
    end
    if (req_valid_i) begin
      use_q <= act_q;
      off_q <= offset_i;
      fs_q  <= fsgs_i;
      ovr_q <= addr_ovr_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_one; req_valid_i |=> (pa_valid_o ^ fault_o); endproperty
  a_one: assert property (p_one) else $error("request without single answer");
  property p_quiet; !req_valid_i |=> !(pa_valid_o || fault_o); endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_hold; !req_valid_i |=> $stable(pa_o) && $stable(lin_o); endproperty
  a_hold: assert property (p_hold) else $error("address changed between requests");
  property p_canon; pa_valid_o |-> (&lin_o[63:47] || ~|lin_o[63:47]); endproperty
  a_canon: assert property (p_canon) else $error("non-canonical linear accepted");
  property p_direct; pa_valid_o && !use_q[8] && md < 3'h2 |-> pa_o == lin_o[LM_PHYS_W-1:0]; endproperty
  a_direct: assert property (p_direct) else $error("unpaged address altered");
  property p_realcap; pa_valid_o && md == 3'h1 |-> lin_o[63:20] == 44'h0; endproperty
  a_realcap: assert property (p_realcap) else $error("real linear above 20 bits");
  property p_flat64; pa_valid_o && md == 3'h4 && !fs_q && !ovr_q |-> lin_o == off_q; endproperty
  a_flat64: assert property (p_flat64) else $error("64-bit linear differs from offset");
  property p_mgmt; pa_valid_o |-> mgmt_space_o == (md == 3'h2); endproperty
  a_mgmt: assert property (p_mgmt) else $error("management space flag wrong");
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
endmodule // addr_xlat_assertions

bind addr_xlat addr_xlat_assertions #(.LM_PHYS_W(LM_PHYS_W)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .req_valid_i(req_valid_i), .offset_i(offset_i),
  .fsgs_i(fsgs_i), .addr_ovr_i(addr_ovr_i), .boundary_i(boundary_i), .pa_valid_o(pa_valid_o),
  .pa_o(pa_o), .lin_o(lin_o), .fault_o(fault_o), .mgmt_space_o(mgmt_space_o));

// *** xlat_pipe_model.sv ***
`timescale 1ns/100ps
module xlat_pipe_model (
  // clock
  input  wire        clk_i,
  // command from bench
  input  wire        go_i,
  input  wire [15:0] sel_i,
  input  wire [63:0] off_i,
  input  wire        ovr_i,
  // request to translator
  output reg         req_valid_o = 1'b0,
  output reg  [15:0] selector_o = 16'h0000,
  output reg  [63:0] offset_o = 64'h0,
  output reg         addr_ovr_o = 1'b0
);
  // one-cycle request; operands scrambled once released
  always @(posedge clk_i) begin
    req_valid_o <= go_i;
    if (go_i) begin
      selector_o <= sel_i;
      offset_o   <= off_i;
      addr_ovr_o <= ovr_i;
    end else if (req_valid_o) begin
      selector_o <= ~selector_o;
      offset_o   <= ~offset_o;
      addr_ovr_o <= ~addr_ovr_o;
    end
  end
endmodule // xlat_pipe_model

// *** test_logical_address_translation.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module test_logical_address_translation;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         bus_cs = 1'b0;
  reg         we_i = 1'b0;
  reg  [7:0]  adr_i = 8'h00;
  reg  [31:0] dat_i = 32'h0000_0000;
  reg         go = 1'b0;
  reg  [15:0] sel_c = 16'h0000;
  reg  [63:0] off_c = 64'h0;
  reg         ovr_c = 1'b0;
  reg         boundary_i = 1'b0;
  wire [31:0] dat_o;
  wire        ack_o, req_valid, addr_ovr, pa_valid_o, fault_o, mgmt_space_o;
  wire [15:0] selector;
  wire [63:0] offset, lin_o;
  wire [45:0] pa_o;
  wire [2:0]  fault_code_o;
  integer     fail_count = 0;
  integer     checks_done = 0;
  integer     cyc_cnt = 0;

  always #5 clk_i = ~clk_i;

  xlat_pipe_model pipe_u (.clk_i(clk_i), .go_i(go), .sel_i(sel_c), .off_i(off_c), .ovr_i(ovr_c),
    .req_valid_o(req_valid), .selector_o(selector), .offset_o(offset), .addr_ovr_o(addr_ovr));

  addr_xlat dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(bus_cs), .stb_i(bus_cs), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .req_valid_i(req_valid), .selector_i(selector), .offset_i(offset), .fsgs_i(1'b0),
    .addr_ovr_i(addr_ovr), .boundary_i(boundary_i), .pa_valid_o(pa_valid_o), .pa_o(pa_o),
    .lin_o(lin_o), .fault_o(fault_o), .fault_code_o(fault_code_o), .mgmt_space_o(mgmt_space_o));

  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fail_count++;
      results;
    end
  end

  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      bus_cs <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      bus_cs <= 1'b0;
      we_i <= 1'b0;
    end
  endtask

  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      `CHK(dat_o, e)
    end
  endtask

  task cfg(input [31:0] c);
    begin
      bus(1'b1, 8'h00, c);
      @(posedge clk_i);
      boundary_i <= 1'b1;
      @(posedge clk_i);
      boundary_i <= 1'b0;
    end
  endtask

  task xl(input [15:0] s, input [63:0] o, input v, input [2:0] code, input [63:0] lin, input [45:0] pa);
    begin
      @(posedge clk_i);
      go <= 1'b1;
      sel_c <= s;
      off_c <= o;
      ovr_c <= v;
      @(posedge clk_i);
      go <= 1'b0;
      do @(posedge clk_i); while (pa_valid_o !== 1'b1 && fault_o !== 1'b1);
      `CHK(fault_code_o, code)
      if (code == 3'h0) begin
        `CHK(lin_o, lin)
        `CHK(pa_o, pa)
      end
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h00, 32'h0000_0001);
    rd_chk(8'h04, 32'h0003_0000);
    rd_chk(8'hFC, 32'h0000_0000);
    // real-address mode
    xl(16'h1234, 64'h10, 1'b0, 3'h0, 64'h1_2350, 46'h1_2350);
    xl(16'hFFFF, 64'h10, 1'b0, 3'h0, 64'h0, 46'h0);
    xl(16'h0000, 64'h1_0005, 1'b0, 3'h0, 64'h5, 46'h5);
    xl(16'h0000, 64'h1_1000, 1'b1, 3'h0, 64'h1_1000, 46'h1_1000);
    xl(16'hF000, 64'h1_0000, 1'b1, 3'h5, 64'h0, 46'h0);
    // protected flat, new control waits for the boundary
    bus(1'b1, 8'h00, 32'h0000_1000);
    xl(16'h1234, 64'h10, 1'b0, 3'h0, 64'h1_2350, 46'h1_2350);
    cfg(32'h0000_1000);
    xl(16'h0000, 64'h5_ABCD_0123, 1'b0, 3'h0, 64'hABCD_0123, 46'hABCD_0123);
    xl(16'h0000, 64'h5_ABCD_0123, 1'b1, 3'h0, 64'h0123, 46'h0123);
    xl(16'h0000, 64'h5_ABCD_0123, 1'b0, 3'h0, 64'hABCD_0123, 46'hABCD_0123);
    // segmented and compatibility
    bus(1'b1, 8'h08, 32'h0000_0001);
    bus(1'b1, 8'h0C, 32'h0010_0000);
    bus(1'b1, 8'h10, 32'h0000_0FFF);
    cfg(32'h0000_1010);
    xl(16'h0008, 64'h20, 1'b0, 3'h0, 64'h10_0020, 46'h10_0020);
    xl(16'h0008, 64'h1000, 1'b0, 3'h1, 64'h0, 46'h0);
    xl(16'h0003, 64'h20, 1'b0, 3'h2, 64'h0, 46'h0);
    cfg(32'h0000_1813);
    xl(16'h0008, 64'h20, 1'b0, 3'h0, 64'h10_0020, 46'h10_0020);
    cfg(32'h0000_1013);
    xl(16'h0008, 64'h20, 1'b0, 3'h6, 64'h0, 46'h0);
    // management space
    cfg(32'h0000_0002);
    xl(16'h0001, 64'h2, 1'b0, 3'h0, 64'h12, 46'h3_0012);
    // paging: entry 1 large, entry 0 small with high frame bits
    bus(1'b1, 8'h08, 32'h0000_0100);
    bus(1'b1, 8'h14, 32'h0000_0800);
    bus(1'b1, 8'h18, 32'h0000_0003);
    bus(1'b1, 8'h1C, 32'h0000_0C00);
    bus(1'b1, 8'h08, 32'h0000_0000);
    bus(1'b1, 8'h14, 32'h0000_0405);
    bus(1'b1, 8'h18, 32'h0001_0001);
    bus(1'b1, 8'h1C, 32'h0010_0777);
    cfg(32'h0000_1100);
    xl(16'h0000, 64'h40_5ABC, 1'b0, 3'h0, 64'h40_5ABC, 46'h77_7ABC);
    xl(16'h0000, 64'h40_6000, 1'b0, 3'h4, 64'h0, 46'h0);
    cfg(32'h0000_1300);
    xl(16'h0000, 64'h40_5ABC, 1'b0, 3'h0, 64'h40_5ABC, 46'h1_0077_7ABC);
    cfg(32'h0000_1500);
    xl(16'h0000, 64'h80_1234, 1'b0, 3'h0, 64'h80_1234, 46'hC0_1234);
    // 64-bit mode
    cfg(32'h0000_0B04);
    xl(16'h0000, 64'h40_5ABC, 1'b0, 3'h0, 64'h40_5ABC, 46'h1001_0077_7ABC);
    xl(16'h0000, 64'h1_0040_5ABC, 1'b1, 3'h0, 64'h40_5ABC, 46'h1001_0077_7ABC);
    xl(16'h0000, 64'h1_0000_0000_0000, 1'b0, 3'h3, 64'h0, 46'h0);
    cfg(32'h0000_0A04);
    xl(16'h0000, 64'h10, 1'b0, 3'h6, 64'h0, 46'h0);
    results;
  end
endmodule // test_logical_address_translation
